// >>> hw/rsol_pkg.sv
/*
  shared constants and types of the robot status-output logic: register
  offsets, field positions, reset values, error-code ranges, host command
  and status-output carriers.
  assumes a 32-bit apb slave port and one 25 MHz clock.
*/
`default_nettype none

package rsol_pkg;

  // apb map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_EVENT = 12'h004;
  localparam logic [11:0] OFF_ERRCODE = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;

  // control register fields
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_PENDANTLESS = 2;
  localparam int CTRL_W = 3;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // event register bits, each a one-cycle pulse on write
  localparam int EV_BOOT = 0;
  localparam int EV_PANEL_CLR = 1;
  localparam int EV_MOTOR_ON = 2;
  localparam int EV_MOTOR_OFF = 3;
  localparam int EV_CAL_OK = 4;
  localparam int EV_CAL_FAIL = 5;
  localparam int EV_PEND_EXT_ON = 6;
  localparam int EV_PEND_EXT_OFF = 7;
  localparam int EV_FAIL = 8;
  localparam int EV_WARN = 9;
  localparam int EV_PROG_RUN = 10;
  localparam int EV_PROG_IDLE = 11;
  localparam int EV_PANEL_STOP = 12;
  localparam int EV_W = 13;

  // error code register and power-fault ranges
  localparam int ERR_W = 16;
  localparam logic [15:0] ERR_RESET = 16'h0000;
  localparam logic [15:0] ERR_PF_A_LO = 16'h6071;
  localparam logic [15:0] ERR_PF_A_HI = 16'h607b;
  localparam logic [15:0] ERR_PF_B_LO = 16'h6671;
  localparam logic [15:0] ERR_PF_B_HI = 16'h667b;
  localparam logic [15:0] ERR_PF_C = 16'h607f;

  // status register layout
  localparam int ST_OUT_LSB = 0;
  localparam int ST_CMD_LSB = 8;
  localparam int ST_WARN = 18;
  localparam int ST_FAIL = 19;

  // mode selector position, written by firmware
  typedef enum logic [1:0] {
    RSOL_SEL_MANUAL,
    RSOL_SEL_TEACH,
    RSOL_SEL_AUTO
  } rsol_sel_t;

  // host command pins, level signals
  typedef struct packed {
    logic step_stop;
    logic instant_halt;
    logic auto_permit;
    logic halt;
    logic run_request;
    logic external_mode_request;
    logic calibrate_request;
    logic motor_power_request;
    logic clear_failure;
    logic prepare_start;
  } rsol_cmd_t;

  // status output pins, level signals
  typedef struct packed {
    logic in_operation;
    logic start_ack;
    logic teaching;
    logic external_mode;
    logic cal_complete;
    logic servo_on;
    logic auto_mode;
    logic power_on_complete;
  } rsol_out_t;

endpackage

`default_nettype wire

// >>> hw/rsol_sync.sv
/*
  two-flop level synchroniser, one chain per bit.
  assumes inputs are levels from outside the pclk domain.
*/
`default_nettype none

module rsol_sync #(
  parameter int W = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // one two-stage chain per bit; only stage two is seen outside
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic stab_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q <= 1'b0;
        stab_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        stab_q <= meta_q;
      end
    end
    assign sync_out[i] = stab_q;
  end

endmodule

`default_nettype wire

// >>> hw/rsol_top.sv
/*
  robot status-output logic: drives the level status pins toward the
  external sequencer from its command pins and from firmware events
  written over apb.
  assumes host pins are asynchronous levels, firmware reports panel,
  pendant, calibration, failure and program events through the event
  register, and a single 25 MHz pclk with active-low async reset.
*/
`default_nettype none

module rsol_top (
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host command pins, asynchronous
  input wire rsol_pkg::rsol_cmd_t host_cmd,
  // status pins toward the host
  output rsol_pkg::rsol_out_t status_out
);

  // ------------------------------------------------------------------
  // host command synchronisation
  // ------------------------------------------------------------------

  rsol_pkg::rsol_cmd_t cmd; // synchronised host commands
  logic [$bits(rsol_pkg::rsol_cmd_t)-1:0] cmd_vec; // flat form

  // every host pin passes two flops before use
  rsol_sync #(
    .W($bits(rsol_pkg::rsol_cmd_t))
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(host_cmd),
    .sync_out(cmd_vec)
  );

  assign cmd = rsol_pkg::rsol_cmd_t'(cmd_vec);

  // ------------------------------------------------------------------
  // apb slave
  // ------------------------------------------------------------------

  logic pready_q; // access phase answered
  logic pslverr_q; // error answer for unmapped address
  logic [31:0] prdata_q; // read data
  logic [2:0] ctrl_q; // selector and pendantless
  logic [15:0] err_q; // error code of current failure
  logic [12:0] evt_q; // event pulses, one cycle
  logic [12:0] evt_d;
  logic [31:0] status_word; // read view of block state

  // address decode
  wire hit_ctrl = (paddr == rsol_pkg::OFF_CTRL);
  wire hit_evt = (paddr == rsol_pkg::OFF_EVENT);
  wire hit_err = (paddr == rsol_pkg::OFF_ERRCODE);
  wire hit_st = (paddr == rsol_pkg::OFF_STATUS);
  wire hit_any = hit_ctrl | hit_evt | hit_err | hit_st;

  // the access phase takes two cycles; this edge completes it
  wire acc_start = psel & penable & ~pready_q;
  wire acc_done = psel & penable & pready_q;
  wire wr_done = acc_done & pwrite & hit_any;

  // read mux
  wire [31:0] rd_mux =
    hit_ctrl ? {29'h0, ctrl_q} :
    hit_err ? {16'h0, err_q} :
    hit_st ? status_word : 32'h0;

  // event pulses exist only in the cycle after the write
  assign evt_d = (wr_done & hit_evt) ? pwdata[rsol_pkg::EV_W-1:0] : 13'h0;

  // handshake flops: pready after one access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= acc_start;
      pslverr_q <= acc_start & ~hit_any;
      prdata_q <= (acc_start & ~pwrite) ? rd_mux : 32'h0;
    end
  end

  // software registers; writes land at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= rsol_pkg::CTRL_RESET;
      err_q <= rsol_pkg::ERR_RESET;
      evt_q <= 13'h0;
    end else begin
      if (wr_done & hit_ctrl) begin
        ctrl_q <= pwdata[rsol_pkg::CTRL_W-1:0];
      end
      if (wr_done & hit_err) begin
        err_q <= pwdata[rsol_pkg::ERR_W-1:0];
      end
      evt_q <= evt_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ------------------------------------------------------------------
  // decoded firmware state and events
  // ------------------------------------------------------------------

  rsol_pkg::rsol_sel_t sel; // selector position
  assign sel = rsol_pkg::rsol_sel_t'(ctrl_q[rsol_pkg::CTRL_SEL_LSB +: 2]);
  wire pendantless = ctrl_q[rsol_pkg::CTRL_PENDANTLESS];
  wire sel_auto = (sel == rsol_pkg::RSOL_SEL_AUTO);
  wire sel_manual = ~sel_auto; // manual, teach check or unused code

  wire ev_boot = evt_q[rsol_pkg::EV_BOOT];
  wire ev_panel_clr = evt_q[rsol_pkg::EV_PANEL_CLR];
  wire ev_motor_on = evt_q[rsol_pkg::EV_MOTOR_ON];
  wire ev_motor_off = evt_q[rsol_pkg::EV_MOTOR_OFF];
  wire ev_cal_ok = evt_q[rsol_pkg::EV_CAL_OK];
  wire ev_cal_fail = evt_q[rsol_pkg::EV_CAL_FAIL];
  wire ev_pend_on = evt_q[rsol_pkg::EV_PEND_EXT_ON];
  wire ev_pend_off = evt_q[rsol_pkg::EV_PEND_EXT_OFF];
  wire ev_fail = evt_q[rsol_pkg::EV_FAIL];
  wire ev_warn = evt_q[rsol_pkg::EV_WARN];
  wire ev_prog_run = evt_q[rsol_pkg::EV_PROG_RUN];
  wire ev_prog_idle = evt_q[rsol_pkg::EV_PROG_IDLE];
  wire ev_panel_stop = evt_q[rsol_pkg::EV_PANEL_STOP];

  // host combinations that act only together with prepare-start
  wire host_clear = cmd.clear_failure & cmd.prepare_start;
  wire host_motor = cmd.motor_power_request & cmd.prepare_start;
  wire host_ext = cmd.external_mode_request & cmd.prepare_start;

  // auto is permitted by the pin, or always without a pendant
  wire permit_ok = cmd.auto_permit | pendantless;

  // stop-everything: halt pin, all-task stops, panel stop buttons
  wire stop_all = cmd.halt | cmd.instant_halt | cmd.step_stop | ev_panel_stop;

  // error code lies in one of the power-fault ranges
  wire pf_code =
    ((err_q >= rsol_pkg::ERR_PF_A_LO) & (err_q <= rsol_pkg::ERR_PF_A_HI)) |
    ((err_q >= rsol_pkg::ERR_PF_B_LO) & (err_q <= rsol_pkg::ERR_PF_B_HI)) |
    (err_q == rsol_pkg::ERR_PF_C);

  // ------------------------------------------------------------------
  // failure and warning flags
  // ------------------------------------------------------------------

  logic fail_q; // failure state
  logic fail_d;
  logic warn_q; // warning state
  logic warn_d;
  logic fault_q; // failure or warning, one cycle late
  wire fault_now = fail_q | warn_q;

  // a new failure in the clearing cycle survives: set wins
  assign fail_d = ev_fail | (fail_q & ~(host_clear | ev_panel_clr));
  assign warn_d = ev_warn | (warn_q & ~(host_clear | ev_panel_clr));

  // fault flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fail_q <= 1'b0;
      warn_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      fail_q <= fail_d;
      warn_q <= warn_d;
      fault_q <= fault_now;
    end
  end

  // fault just cleared by panel key or host command
  wire fault_cleared = fault_q & ~fault_now;

  // ------------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------------

  rsol_pkg::rsol_out_t out_q; // registered pins
  rsol_pkg::rsol_out_t out_d;

  // next state of every status pin
  always_comb begin
    out_d = out_q;

    // power-on-complete
    if (fault_now) begin
      out_d.power_on_complete = 1'b0;
    end else if (ev_boot | fault_cleared) begin
      out_d.power_on_complete = 1'b1;
    end

    // auto mode follows selector and permit; stops do not touch it
    out_d.auto_mode = sel_auto & permit_ok;

    // servo on
    if (ev_motor_off | cmd.halt) begin
      out_d.servo_on = 1'b0;
    end else if (fail_q & ~(pf_code & ~out_q.external_mode)) begin
      out_d.servo_on = 1'b0;
    end else if (ev_motor_on | host_motor) begin
      out_d.servo_on = 1'b1;
    end

    // calibration complete
    if (ev_cal_fail) begin
      out_d.cal_complete = 1'b0;
    end else if (ev_cal_ok) begin
      out_d.cal_complete = 1'b1;
    end

    // external mode; step stop is deliberately absent here
    if (sel_manual | cmd.halt | fail_q | ~cmd.auto_permit | ev_pend_off) begin
      out_d.external_mode = 1'b0;
    end else if (host_ext | ev_pend_on) begin
      out_d.external_mode = 1'b1;
    end

    // teaching
    if (sel_manual) begin
      out_d.teaching = 1'b1;
    end else if (cmd.auto_permit) begin
      out_d.teaching = 1'b0;
    end

    // program-start acknowledge, four-phase with run request
    if (~cmd.run_request) begin
      out_d.start_ack = 1'b0;
    end else if (ev_prog_run) begin
      out_d.start_ack = 1'b1;
    end

    // in-operation holds through waits until stopped or idle
    if (stop_all | ev_prog_idle) begin
      out_d.in_operation = 1'b0;
    end else if (ev_prog_run) begin
      out_d.in_operation = 1'b1;
    end
  end

  // status pin flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign status_out = out_q;

  // read view: pins, synchronised commands, fault flags
  assign status_word = {12'h0, fail_q, warn_q, cmd_vec, out_q};

endmodule

`default_nettype wire

// >>> testbench/rsol_top_chk.sv
/*
  port-level assertions for the robot status-output block.
  assumes it is bound into rsol_top with one pclk domain.
*/
`default_nettype none

module rsol_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire rsol_pkg::rsol_cmd_t host_cmd,
  input wire rsol_pkg::rsol_out_t status_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // slave answers in the cycle after the access phase opens
  chk_ready_time: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not one cycle after access");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held over two cycles");
  chk_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h00c))
    else $error("pslverr does not match decode");
  // acknowledge only follows a held run request
  chk_ack_run: assert property ($rose(status_out.start_ack) |-> $past(host_cmd.run_request, 3))
    else $error("start_ack rose without run request");
  chk_ack_falls: assert property ($fell(host_cmd.run_request) |-> ##[1:4] !status_out.start_ack)
    else $error("start_ack stayed after run dropped");
  chk_ext_auto: assert property (status_out.external_mode |-> status_out.auto_mode)
    else $error("external mode outside auto");
  chk_halt_stop: assert property (host_cmd.halt [*3] |=> !status_out.in_operation)
    else $error("in_operation kept under halt");
  chk_halt_servo: assert property (host_cmd.halt [*3] |=> !status_out.servo_on && !status_out.external_mode)
    else $error("servo or external kept under halt");
  chk_motor_req: assert property ((host_cmd.prepare_start && host_cmd.motor_power_request &&
      !host_cmd.halt) [*4] |=> status_out.servo_on)
    else $error("servo not on after motor request");
  // main scenarios reached
  cov_ack: cover property ($rose(status_out.start_ack));
  cov_err: cover property (pready && pslverr);
  cov_poc_drop: cover property ($fell(status_out.power_on_complete));
endmodule

bind rsol_top rsol_top_chk i_rsol_top_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready,
  .pslverr, .host_cmd, .status_out);

`default_nettype wire

// >>> testbench/rsol_host.sv
/*
  behavioural sequencer on the host side of the status pins.
  assumes the bench gives wanted levels and a one-cycle go strobe.
*/
`default_nettype none

module rsol_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire rsol_pkg::rsol_cmd_t want,
  input wire logic go,
  input wire rsol_pkg::rsol_out_t st,
  output rsol_pkg::rsol_cmd_t host_cmd
);
  logic run_q;
  logic ok_q;
  // drive wanted levels, own the run handshake
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      ok_q <= 1'b0;
      host_cmd <= '0;
    end else begin
      if (st.power_on_complete && st.auto_mode) begin
        ok_q <= 1'b1;
      end
      if (go && st.auto_mode) begin
        run_q <= 1'b1;
      end else if (st.start_ack) begin
        run_q <= 1'b0;
      end
      host_cmd <= want;
      host_cmd.prepare_start <= want.prepare_start && ok_q;
      host_cmd.run_request <= run_q;
    end
  end
endmodule

`default_nettype wire

// >>> testbench/tb.sv
/*
  self-checking bench for the robot status-output block.
  assumes rsol_top, its package and the host model are compiled first.
*/
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, go;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] code;
  rsol_pkg::rsol_cmd_t want, host_cmd;
  rsol_pkg::rsol_out_t st;
  int num_errors, cmp_count, i;
  int cyc = 0;

  rsol_top i_rsol_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .host_cmd, .status_out(st));
  rsol_host i_rsol_host (.pclk, .presetn, .want, .go, .st, .host_cmd);

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task conclude();
    $display("errors %0d checks %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task check(string nm, logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  task tick(int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; read data and error land in rd and er
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer; only the hang guard ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // firmware event pulse, then let status settle
  task ev(int b);
    apb(1'b1, 12'h004, 32'h1 << b);
    tick(6);
  endtask

  function automatic logic pf(logic [15:0] c);
    return (c >= 16'h6071 && c <= 16'h607b) || (c >= 16'h6671 && c <= 16'h667b) || c == 16'h607f;
  endfunction

  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      num_errors++;
      conclude();
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, go} = '0;
    want = '0;
    presetn = 1'b0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(61));
    tick(6);
    presetn <= 1'b1;
    tick(2);
    check("status", st, 8'h20);
    apb(1'b0, 12'h000, 0);
    check("ctrl", rd, 0);
    ev(0);
    check("poc", st.power_on_complete, 1);
    want <= 10'h080;
    apb(1'b1, 12'h000, 2);
    tick(6);
    check("status", st, 8'h03);
    want <= 10'h09d;
    tick(8);
    check("status", st, 8'h17);
    apb(1'b0, 12'h00c, 0);
    check("cal req", rd[11], 1);
    ev(4);
    check("cal", st.cal_complete, 1);
    go <= 1'b1;
    @(posedge pclk) go <= 1'b0;
    tick(4);
    ev(10);
    tick(4);
    check("status", st, 8'h9f);
    for (i = 0; i < 2; i++) begin
      ev(10);
      check("inop", st.in_operation, 1);
      if (i == 1) want.instant_halt <= 1'b1;
      else want.step_stop <= 1'b1;
      tick(6);
      check("status", st, 8'h1f);
      want <= 10'h09d;
      tick(4);
    end
    want <= 10'h080;
    apb(1'b1, 12'h008, 32'h6075);
    ev(8);
    check("status", st, 8'h0a);
    want <= 10'h083;
    tick(6);
    check("poc", st.power_on_complete, 1);
    want <= 10'h080;
    apb(1'b1, 12'h000, 0);
    for (i = 0; i < 6; i++) begin
      code = (i % 3 == 0) ? 16'h6671 + 16'($urandom % 11) :
        (i % 3 == 1) ? 16'h607f : 16'h1000 + 16'($urandom % 16'h4000);
      apb(1'b1, 12'h008, {16'h0, code});
      apb(1'b0, 12'h008, 0);
      check("errcode", rd, {16'h0, code});
      ev(2);
      ev(8 + i % 2);
      check("servo", st.servo_on, (i % 2) ? 1'b1 : pf(code));
      check("poc", st.power_on_complete, 0);
      ev(1);
      check("poc", st.power_on_complete, 1);
    end
    ev(5);
    check("cal", st.cal_complete, 0);
    apb(1'b1, 12'h000, 2);
    ev(2);
    ev(6);
    check("status", st, 8'h17);
    want <= 10'h0c0;
    tick(6);
    check("status", st, 8'h03);
    want <= 10'h000;
    tick(6);
    check("auto", st.auto_mode, 0);
    apb(1'b1, 12'h000, 6);
    tick(6);
    check("auto", st.auto_mode, 1);
    apb(1'b1, 12'h000, 1);
    tick(6);
    check("teach", st, 8'h21);
    apb(1'b0, 12'h010, 0);
    check("unmapped", {rd[30:0], er}, 1);
    conclude();
  end
endmodule

`default_nettype wire
